// file: nvsram_cmd_table.sv
// Registered lookup of the six command addresses for each software command.
// Assumes the parent presents command and step; the address appears one cycle later.
`include "nvsram_host_cfg.svh"
`default_nettype none
module nvsram_cmd_table #(
	parameter logic [6*`ADDR_W-1:0] SAVE_ADDRS    = {6{15'h0000}},
	parameter logic [6*`ADDR_W-1:0] RESTORE_ADDRS = {6{15'h0000}},
	parameter logic [6*`ADDR_W-1:0] ASE_ON_ADDRS  = {6{15'h0000}},
	parameter logic [6*`ADDR_W-1:0] ASE_OFF_ADDRS = {6{15'h0000}}
) (
	input  wire logic                i_clock,
	input  wire logic                i_ce,
	input  wire logic [1:0]          i_cmd,
	input  wire logic [2:0]          i_step,
	output var  logic [`ADDR_W-1:0]  o_addr
);
	// The table is parameters since each part variant may use its own addresses.
	wire logic [6*`ADDR_W-1:0] row_sel;
	wire logic [`ADDR_W-1:0]   entry;
	assign row_sel = (i_cmd == `CMD_SAVE)    ? SAVE_ADDRS :
	                 (i_cmd == `CMD_RESTORE) ? RESTORE_ADDRS :
	                 (i_cmd == `CMD_ASE_ON)  ? ASE_ON_ADDRS : ASE_OFF_ADDRS;
	assign entry = row_sel[i_step*`ADDR_W +: `ADDR_W];

	// Registered read data, so the parent copies it to the pins on the same edge that drops the strobes.
	always_ff @(posedge i_clock) begin
		if (i_ce) begin
			o_addr <= entry;
		end
	end
endmodule // nvsram_cmd_table
`default_nettype wire

// file: nvsram_dev_model.sv
// Behavioural byte-wide SRAM with shadow cells, facing the controller's pins.
// Assumes pins change on the host clock; the bench resolves the save line with a pull-up.
`default_nettype none
module nvsram_dev_model #(
	parameter int           BUSY = 16,
	parameter logic [359:0] TBL  = '0
) (
	input  wire logic        i_clock,
	input  wire logic        i_cs_n,
	input  wire logic        i_we_n,
	input  wire logic        i_oe_n,
	input  wire logic [14:0] i_addr,
	input  wire logic [7:0]  i_dq,
	input  wire logic        i_hsb,
	output var  logic [7:0]  o_dq,
	output wire logic        o_hsb_pull,
	output var  logic        o_latch = 1'b0,
	output var  logic [2:0]  o_cmd = 3'h7
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0]  mem [32768];
	logic [89:0] hist = '1;
	logic [7:0]  pat = 8'h00;
	logic        rd_q = 1'b0;
	int          busy = 0;
	wire         rd = !i_cs_n && i_we_n && !i_oe_n && busy == 0;
	assign o_hsb_pull = busy != 0;
	// A released bus shows a moving pattern, so stale data never looks valid.
	always_comb o_dq = rd ? mem[i_addr] : pat;
	// Writes, the six-read window and the save engine advance on the host clock.
	always @(posedge i_clock) begin
		pat <= pat + 8'h5B;
		rd_q <= rd;
		if (busy != 0)
			busy <= busy - 1;
		else if (!i_cs_n && !i_we_n) begin
			mem[i_addr] <= i_dq;
			o_latch <= 1'b1;
			hist <= '1;
		end else if (rd && !rd_q) begin
			hist <= {hist[74:0], i_addr};
			for (int c = 0; c < 4; c++)
				if ({hist[74:0], i_addr} == TBL[c*90+:90]) begin
					o_cmd <= 3'(c);
					busy <= BUSY;
					hist <= '1;
					if (c < 2)
						o_latch <= 1'b0;
				end
		end else if (!i_hsb && o_latch) begin
			busy <= BUSY;
			o_latch <= 1'b0;
		end
	end
endmodule // nvsram_dev_model
`default_nettype wire

// file: nvsram_host.sv
// Host controller that drives the strobes, address and data pins of a byte-wide SRAM with shadow cells.
// Assumes device pins are synchronous to i_clock and the bench resolves the bidirectional data bus.
// The command addresses are parameters that default to zero; a user must set them for the part fitted.
`include "nvsram_host_cfg.svh"
`default_nettype none
module nvsram_host
	import nvsram_host_pkg::*;
#(
	parameter logic [6*`ADDR_W-1:0] SAVE_ADDRS    = {6{15'h0000}},
	parameter logic [6*`ADDR_W-1:0] RESTORE_ADDRS = {6{15'h0000}},
	parameter logic [6*`ADDR_W-1:0] ASE_ON_ADDRS  = {6{15'h0000}},
	parameter logic [6*`ADDR_W-1:0] ASE_OFF_ADDRS = {6{15'h0000}},
	parameter int                   PROC_CYCLES   = `CMD_PROC_TIME_CYC
) (
	input  wire logic                i_clock,
	input  wire logic                i_rst,
	input  wire logic                i_ce,
	input  wire logic                i_req_valid,
	input  wire logic [1:0]          i_req_op,
	input  wire logic [1:0]          i_req_cmd,
	input  wire logic [`ADDR_W-1:0]  i_req_addr,
	input  wire logic [`DATA_W-1:0]  i_req_wdata,
	output var  logic                o_req_ready,
	output var  logic                o_done,
	output var  logic [`DATA_W-1:0]  o_rdata,
	output var  logic                o_chip_sel_n,
	output var  logic                o_write_n,
	output var  logic                o_out_en_n,
	output var  logic [`ADDR_W-1:0]  o_addr,
	output var  logic [`DATA_W-1:0]  o_dq_out,
	output var  logic                o_dq_oe,
	input  wire logic [`DATA_W-1:0]  i_dq_in,
	output var  logic                o_hw_save_busy_n_out,
	output var  logic                o_hw_save_busy_n_oe,
	input  wire logic                i_hw_save_busy_n
);
	// Every pin time is rounded up to whole clock cycles, so the device always sees
	// at least the minimum width; the cost is up to one extra cycle per phase.
	// The processing wait is a parameter so that simulation can shorten it.
	localparam logic [15:0] PULSE_CYC = 16'(`CYCLE_CYC);
	localparam logic [15:0] HSB_CYC   = 16'(`HW_SAVE_PULSE_MIN_CYC);
	localparam logic [15:0] WFW_CYC   = 16'(`WRITE_FINISH_WINDOW_CYC);
	localparam logic [23:0] PROC_CYC  = 24'(PROC_CYCLES);
	localparam logic [2:0]  LAST_STEP = 3'(`SEQ_LEN - 1);

	host_state_t          state_r, state_nxt;
	host_op_t             op_r;
	logic [1:0]           cmd_r;
	logic [2:0]           step_r;
	logic [23:0]          cnt_r;
	logic [`ADDR_W-1:0]   req_addr_r;
	wire logic [`ADDR_W-1:0] tbl_addr;
	wire logic [1:0]         tbl_cmd;
	wire logic [2:0]         tbl_step;
	wire logic            cnt_zero;
	wire logic            is_seq;
	wire logic            is_wr;
	wire logic            last_step;
	wire logic            take;

	// The table answers one cycle late, so it is addressed with the values that the
	// command and step registers are about to take. That way the address for a step is
	// ready in ST_SETUP, when it is copied to the pins, with no extra wait per step.
	nvsram_cmd_table #(
		.SAVE_ADDRS    (SAVE_ADDRS),
		.RESTORE_ADDRS (RESTORE_ADDRS),
		.ASE_ON_ADDRS  (ASE_ON_ADDRS),
		.ASE_OFF_ADDRS (ASE_OFF_ADDRS)
	) u_table (
		.i_clock (i_clock),
		.i_ce    (i_ce),
		.i_cmd   (tbl_cmd),
		.i_step  (tbl_step),
		.o_addr  (tbl_addr)
	);

	// Request acceptance and decoded conditions.
	assign cnt_zero  = (cnt_r == 24'h000000);
	assign is_seq    = (op_r == OP_SEQ);
	assign is_wr     = (op_r == OP_WRITE);
	assign last_step = (step_r == LAST_STEP);
	assign take      = (state_r == ST_IDLE) && i_req_valid;
	// Look-ahead of the table index: a new command starts at step zero, and a gap
	// moves on to the next step unless the sequence is at its end.
	assign tbl_cmd   = take ? i_req_cmd : cmd_r;
	assign tbl_step  = take ? 3'h0 : (state_r == ST_GAP && !last_step) ? step_r + 3'h1 : step_r;

	// Next state; ST_PULSE and ST_HSAVE wait for the counter to run out, ST_WAIT for it or, after a save, the busy line.
	// A transfer is ST_SETUP (address and strobes launched), ST_PULSE (strobes low for
	// the cycle time) and ST_GAP (strobes high again), so back-to-back reads of a command
	// sequence are separated by two cycles with chip select high.
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE:  begin
				if (take) begin
					state_nxt = (host_op_t'(i_req_op) == OP_HSAVE) ? ST_HSAVE : ST_SETUP;
				end
			end
			ST_SETUP: state_nxt = ST_PULSE;
			ST_PULSE: begin
				if (cnt_zero) begin
					state_nxt = ST_GAP;
				end
			end
			ST_GAP:   begin
				if (!is_seq) begin
					state_nxt = ST_DONE;
				end else if (last_step) begin
					state_nxt = ST_WAIT;
				end else begin
					state_nxt = ST_SETUP;
				end
			end
			ST_HSAVE: begin
				if (cnt_zero) begin
					state_nxt = ST_WAIT;
				end
			end
			ST_WAIT:  begin
				// The busy line is sampled too, so a fast skipped save ends early.
				// The first few cycles are skipped, so the line is not read while the
				// device may still be deciding whether a save is needed.
				if (cnt_zero || (op_r == OP_HSAVE && i_hw_save_busy_n && cnt_r < PROC_CYC - WFW_CYC)) begin
					state_nxt = ST_DONE;
				end
			end
			ST_DONE:  state_nxt = ST_IDLE;
			default:  state_nxt = ST_IDLE;
		endcase
	end

	// State, counter and request capture.
	// The counter is shared: it times the strobe pulse, the save request pulse and
	// the wait after a command or save, since only one of these runs at a time.
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			state_r    <= ST_IDLE;
			op_r       <= OP_READ;
			cmd_r      <= 2'h0;
			step_r     <= 3'h0;
			cnt_r      <= 24'h000000;
			req_addr_r <= '0;
		end else if (i_ce) begin
			state_r <= state_nxt;
			if (take) begin
				op_r       <= host_op_t'(i_req_op);
				cmd_r      <= i_req_cmd;
				step_r     <= 3'h0;
				req_addr_r <= i_req_addr;
				cnt_r      <= 24'(HSB_CYC - 16'h0001);
			end else if (state_r == ST_SETUP) begin
				cnt_r <= 24'(PULSE_CYC - 16'h0001);
			end else if (state_r == ST_GAP) begin
				step_r <= step_r + 3'h1;
				cnt_r  <= PROC_CYC;
			end else if (state_r == ST_HSAVE && cnt_zero) begin
				cnt_r <= PROC_CYC;
			end else if (!cnt_zero) begin
				cnt_r <= cnt_r - 24'h000001;
			end
		end
	end

	// Pin drive. Strobes leave the device in standby outside ST_PULSE.
	// All pins come from flip-flops, the strobes and enables fed by the next state, so these
	// change together on one edge and no decode glitch ever reaches the device.
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_chip_sel_n         <= 1'b1;
			o_write_n            <= 1'b1;
			o_out_en_n           <= 1'b1;
			o_addr               <= '0;
			o_dq_out             <= '0;
			o_dq_oe              <= 1'b0;
			o_hw_save_busy_n_out <= 1'b0;
			o_hw_save_busy_n_oe  <= 1'b0;
		end else if (i_ce) begin
			o_chip_sel_n <= !(state_nxt == ST_PULSE);
			o_write_n    <= !(state_nxt == ST_PULSE && is_wr);
			o_out_en_n   <= !(state_nxt == ST_PULSE && !is_wr);
			if (state_r == ST_SETUP) begin
				o_addr <= is_seq ? tbl_addr : req_addr_r;
			end
			o_dq_oe             <= (state_nxt == ST_PULSE) && is_wr;
			o_dq_out            <= i_req_wdata;
			// The line is only pulled low, never driven high, since the device may drive it as busy.
			o_hw_save_busy_n_oe <= (state_nxt == ST_HSAVE);
		end
	end

	// Handshake and read data; the last command read is never reported.
	// Only plain reads update the read data, so the possibly invalid data of the
	// sixth command read can never reach the requester.
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_req_ready <= 1'b0;
			o_done      <= 1'b0;
			o_rdata     <= '0;
		end else if (i_ce) begin
			o_req_ready <= (state_nxt == ST_IDLE);
			o_done      <= (state_nxt == ST_DONE);
			if (state_r == ST_PULSE && cnt_zero && op_r == OP_READ) begin
				o_rdata <= i_dq_in;
			end
		end
	end
endmodule // nvsram_host
`default_nettype wire

// file: nvsram_host_cfg.svh
// Constants of the nonvolatile SRAM host controller: pin timing and command codes.
// Assumes a 100 MHz clock; all times are converted to cycle counts here.
`ifndef NVSRAM_HOST_CFG_SVH
`define NVSRAM_HOST_CFG_SVH
`define CLK_PERIOD_NS            10
`define ADDR_W                   15
`define DATA_W                   8
`define CYCLE_TIME_NS            25
`define CYCLE_CYC                ((`CYCLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HW_SAVE_PULSE_MIN_NS     15
`define HW_SAVE_PULSE_MIN_CYC    ((`HW_SAVE_PULSE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_FINISH_WINDOW_NS   25
`define WRITE_FINISH_WINDOW_CYC  ((`WRITE_FINISH_WINDOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CMD_PROC_TIME_US         100
`define CMD_PROC_TIME_CYC        (`CMD_PROC_TIME_US * 1000 / `CLK_PERIOD_NS)
`define SEQ_LEN                  6
`define CMD_SAVE                 2'h0
`define CMD_RESTORE              2'h1
`define CMD_ASE_ON               2'h2
`define CMD_ASE_OFF              2'h3
`endif

// file: nvsram_host_monitor.sv
// Concurrent checks on the host controller's strobes and save line.
// Assumes it is bound into the controller and sees only that module's ports.
`include "nvsram_host_cfg.svh"
`default_nettype none
module nvsram_host_monitor (
	input wire logic               i_clock,
	input wire logic               i_rst,
	input wire logic               i_req_valid,
	input wire logic [1:0]         i_req_op,
	input wire logic               o_req_ready,
	input wire logic               o_done,
	input wire logic [`DATA_W-1:0] o_rdata,
	input wire logic               o_chip_sel_n,
	input wire logic               o_write_n,
	input wire logic               o_out_en_n,
	input wire logic               o_dq_oe,
	input wire logic               o_hw_save_busy_n_out,
	input wire logic               o_hw_save_busy_n_oe
);
	logic seq_r;
	wire  take = i_req_valid && o_req_ready;
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst);
	// Marks a software sequence from its take to its done, so strobes can be judged against it.
	always_ff @(posedge i_clock)
		seq_r <= i_rst ? 1'b0 : (take && i_req_op == 2'h2) ? 1'b1 : o_done ? 1'b0 : seq_r;
	property p_rd; !o_out_en_n |-> o_write_n && !o_dq_oe; endproperty
	a_rd: assert property (p_rd) else $error("output strobe with write");
	property p_walk; take && i_req_op == 2'h0 |-> ##2 (!o_chip_sel_n && !o_out_en_n)[*3] ##1 o_chip_sel_n; endproperty
	a_walk: assert property (p_walk) else $error("read strobe timing");
	property p_idle; !o_chip_sel_n |-> !o_hw_save_busy_n_oe; endproperty
	a_idle: assert property (p_idle) else $error("save line low in access");
	property p_pulse; $rose(o_hw_save_busy_n_oe) |-> o_hw_save_busy_n_oe[*2]; endproperty
	a_pulse: assert property (p_pulse) else $error("save pulse short");
	property p_sink; o_hw_save_busy_n_oe |-> !o_hw_save_busy_n_out; endproperty
	a_sink: assert property (p_sink) else $error("save line driven high");
	property p_we; seq_r |-> o_write_n; endproperty
	a_we: assert property (p_we) else $error("write in sequence");
	property p_dq; seq_r |-> !o_dq_oe; endproperty
	a_dq: assert property (p_dq) else $error("bus driven in sequence");
	property p_keep; seq_r |-> $stable(o_rdata); endproperty
	a_keep: assert property (p_keep) else $error("sequence data returned");
endmodule // nvsram_host_monitor
`default_nettype wire

// file: nvsram_host_pkg.sv
// Types used by the host controller: its state encoding and request operations.
// Assumes the constants header is compiled alongside.
`default_nettype none
package nvsram_host_pkg;
	typedef enum logic [6:0] {
		ST_IDLE  = 7'b0000001,
		ST_SETUP = 7'b0000010,
		ST_PULSE = 7'b0000100,
		ST_GAP   = 7'b0001000,
		ST_HSAVE = 7'b0010000,
		ST_WAIT  = 7'b0100000,
		ST_DONE  = 7'b1000000
	} host_state_t;
	typedef enum logic [1:0] {
		OP_READ  = 2'h0,
		OP_WRITE = 2'h1,
		OP_SEQ   = 2'h2,
		OP_HSAVE = 2'h3
	} host_op_t;
endpackage
`default_nettype wire

// file: nvsram_host_test.sv
// Self-checking bench: host controller against the behavioural device model.
// Assumes header, package, controller, checker and model are compiled first.
`include "nvsram_host_cfg.svh"
`default_nettype none
module nvsram_host_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_clock = 0, i_rst = 1, v = 0, rdy, done, cs_n, we_n, oe_n, dq_oe, hs_o, hs_oe, pull, latch;
	logic [1:0]  k = 0, c = 0;
	logic [14:0] a = 0, addr, ra [8];
	logic [7:0]  d = 0, rdata, dq_h, dq_d, rv [8];
	logic [2:0]  code;
	int          n_mismatch = 0, n_checks = 0, cyc;
	wire         hw_save_busy_n = !(hs_oe || pull); // Pulled up unless a party sinks it.
	// Command tables are palindromes, so step order reads the same from either end.
	function automatic logic [14:0] ta(int t, int i);
		return 15'h4000 + 15'(t * 16 + (i < 3 ? i : 5 - i));
	endfunction
	function automatic logic [89:0] tb(int t);
		for (int i = 0; i < 6; i++)
			tb[i*15+:15] = ta(t, i);
	endfunction
	nvsram_host #(.SAVE_ADDRS(tb(0)), .RESTORE_ADDRS(tb(1)), .ASE_ON_ADDRS(tb(2)), .ASE_OFF_ADDRS(tb(3)),
		.PROC_CYCLES(20)) u_dut (.i_clock(i_clock), .i_rst(i_rst), .i_ce(1'b1), .i_req_valid(v), .i_req_op(k),
		.i_req_cmd(c), .i_req_addr(a), .i_req_wdata(d), .o_req_ready(rdy), .o_done(done), .o_rdata(rdata),
		.o_chip_sel_n(cs_n), .o_write_n(we_n), .o_out_en_n(oe_n), .o_addr(addr), .o_dq_out(dq_h),
		.o_dq_oe(dq_oe), .i_dq_in(dq_d), .o_hw_save_busy_n_out(hs_o), .o_hw_save_busy_n_oe(hs_oe),
		.i_hw_save_busy_n(hw_save_busy_n));
	nvsram_dev_model #(.TBL({tb(3), tb(2), tb(1), tb(0)})) u_dev (.i_clock(i_clock), .i_cs_n(cs_n),
		.i_we_n(we_n), .i_oe_n(oe_n), .i_addr(addr), .i_dq(dq_h), .i_hsb(hw_save_busy_n), .o_dq(dq_d),
		.o_hsb_pull(pull), .o_latch(latch), .o_cmd(code));
	task automatic chk(string s, logic [7:0] e, logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", s, e, g);
		end
	endtask
	// One request; returns the cycles from take to done, bounded so a lost done cannot hang.
	task automatic op(logic [1:0] nk, logic [1:0] nc, logic [14:0] na, logic [7:0] nd);
		v <= 1;
		k <= nk;
		c <= nc;
		a <= na;
		d <= nd;
		cyc = 0;
		do @(posedge i_clock); while (rdy !== 1);
		v <= 0;
		do begin
			@(posedge i_clock);
			cyc++;
		end while (done !== 1 && cyc < 500);
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial forever #5 i_clock = ~i_clock;
	// Watchdog well beyond the few hundred cycles the sequence needs.
	initial begin
		repeat (5000) @(posedge i_clock);
		n_mismatch++;
		finish_test();
	end
	// Random array traffic, every command, a broken sequence and both save outcomes.
	initial begin
		void'($urandom(32'hC071));
		repeat (12) @(posedge i_clock);
		i_rst <= 0;
		@(posedge i_clock);
		for (int i = 0; i < 8; i++) begin
			ra[i] = {1'b0, 3'(i), 11'($urandom)};
			rv[i] = 8'($urandom);
			op(2'h1, 2'h0, ra[i], rv[i]);
		end
		for (int i = 7; i >= 0; i--) begin
			op(2'h0, 2'h0, ra[i], 8'h00);
			chk("read", rv[i], rdata);
		end
		for (int t = 0; t < 4; t++) begin
			op(2'h2, 2'(t), 15'h0000, 8'h00);
			chk("command", 8'(t), {5'h00, code});
			chk("sixth data", rv[0], rdata);
			chk("command wait", 8'h01, 8'(cyc >= 6 * 5 + 20));
		end
		for (int i = 0; i < 5; i++)
			op(2'h0, 2'h0, ta(1, i), 8'h00);
		op(2'h1, 2'h0, 15'h0124, 8'hA5);
		op(2'h0, 2'h0, ta(1, 5), 8'h00);
		chk("broken sequence", 8'h03, {5'h00, code});
		chk("latch set", 8'h01, {7'h00, latch});
		op(2'h3, 2'h0, 15'h0000, 8'h00);
		chk("latch after save", 8'h00, {7'h00, latch});
		op(2'h2, 2'h0, 15'h0000, 8'h00);
		op(2'h3, 2'h0, 15'h0000, 8'h00);
		chk("skip fast", 8'h01, 8'(cyc < 14));
		op(2'h1, 2'h0, 15'h0125, 8'h3C);
		op(2'h3, 2'h0, 15'h0000, 8'h00);
		chk("latch cleared", 8'h00, {7'h00, latch});
		chk("save busy", 8'h01, 8'(cyc > 16));
		finish_test();
	end
endmodule // nvsram_host_test
bind nvsram_host nvsram_host_monitor u_mon (.*);
`default_nettype wire
